// File: core/lstc_core.sv
// load switch policy, panel lock and trigger terminals behind an
// Avalon-MM slave; panel keys and trig_out_req come from logic on sys_clk,
// trig_in_pin comes from a connector and is synchronised here
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module lstc_core
	import lstc_pkg::*;
#(
	parameter int DLY_MAX = DLY_MAX_CYC,
	parameter int WID_MAX = WID_MAX_CYC
) (
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	input  wire logic              ce,
	input  wire logic [ADDR_W-1:0] avs_address,
	input  wire logic              avs_read,
	input  wire logic              avs_write,
	input  wire logic [31:0]       avs_writedata,
	input  wire logic [3:0]        avs_byteenable,
	output logic [31:0]            avs_readdata,
	output logic                   avs_waitrequest,
	input  wire logic              nv_restore_en,
	input  wire logic [1:0]        nv_restore_item,
	input  wire keys_s             panel_keys,
	output logic                   key_other_ok,
	output logic                   load_on,
	output logic                   short_on,
	output logic                   lock_led,
	output op_s                    op_out,
	output logic                   restore_req,
	output logic [1:0]             restore_item,
	input  wire logic              trig_in_pin,
	input  wire logic              trig_out_req,
	output logic                   trig_out_pin,
	output logic                   trig_action
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	ctrl_s            ctrl_q;
	op_s              op_q;
	op_s              op_d;
	boot_e            boot_q;
	logic             ack_q;
	logic             acc;
	logic             wr_en;
	logic [31:0]      wr_word;
	logic [31:0]      rd_d;
	logic [CNT_W-1:0] dly_q;
	logic [CNT_W-1:0] wid_q;
	logic             mode_chg;
	logic             range_chg;
	logic             force_off;
	logic             load_acc;
	logic             short_acc;
	logic             lock_q;
	logic             trig_in_s;
	logic             trig_in_prev_q;
	logic             in_edge;
	logic             dly_start;
	logic             dly_busy;
	logic             dly_done;
	logic             out_start;
	logic             out_busy;

	// ----------------------------------------------------------------
	// bus slave: one wait state, then the request is taken
	// ----------------------------------------------------------------
	assign acc             = (avs_read || avs_write) && !ack_q;
	assign avs_waitrequest = !ack_q;
	assign wr_en           = ce && avs_write && ack_q;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	always_comb begin
		wr_word = 32'h0000_0000;
		if (avs_address == OFS_CTRL) begin
			wr_word = merge({23'h0, ctrl_q}, avs_writedata, avs_byteenable);
		end else if (avs_address == OFS_OPMODE) begin
			wr_word = merge({28'h0, op_q}, avs_writedata, avs_byteenable);
		end else if (avs_address == OFS_DELAY) begin
			wr_word = merge({15'h0, dly_q}, avs_writedata, avs_byteenable);
		end else if (avs_address == OFS_WIDTH) begin
			wr_word = merge({15'h0, wid_q}, avs_writedata, avs_byteenable);
		end
	end

	always_comb begin
		rd_d = 32'h0000_0000;
		if (avs_address == OFS_CTRL) begin
			rd_d = {23'h0, ctrl_q};
		end else if (avs_address == OFS_OPMODE) begin
			rd_d = {28'h0, op_q};
		end else if (avs_address == OFS_DELAY) begin
			rd_d = {15'h0, dly_q};
		end else if (avs_address == OFS_WIDTH) begin
			rd_d = {15'h0, wid_q};
		end else if (avs_address == OFS_STATUS) begin
			rd_d = {26'h0, boot_q == ST_RUN, out_busy, dly_busy, lock_q, short_on, load_on};
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ack_q        <= 1'b0;
			avs_readdata <= 32'h0000_0000;
		end else if (ce) begin
			ack_q <= acc;
			if (acc && avs_read) begin
				avs_readdata <= rd_d;
			end
		end
	end

	// ----------------------------------------------------------------
	// control register and power-up restore
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q       <= ctrl_s'(CTRL_RST);
			boot_q       <= ST_BOOT;
			restore_req  <= 1'b0;
			restore_item <= 2'h0;
		end else if (ce) begin
			restore_req <= 1'b0;
			case (boot_q)
				ST_BOOT: begin
					// stored option is picked up once, after reset release
					ctrl_q.restore_en   <= nv_restore_en;
					ctrl_q.restore_item <= restore_item_e'(nv_restore_item);
					restore_req         <= nv_restore_en;
					restore_item        <= nv_restore_item;
					boot_q              <= ST_RUN;
				end
				default: begin
					if (wr_en && avs_address == OFS_CTRL) begin
						ctrl_q <= ctrl_s'(wr_word[8:0]);
					end
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// operating mode, range and timing settings
	// ----------------------------------------------------------------
	assign op_d      = op_s'(wr_word[3:0]);
	assign op_out    = op_q;
	assign mode_chg  = wr_en && avs_address == OFS_OPMODE && op_d.mode != op_q.mode;
	assign range_chg = wr_en && avs_address == OFS_OPMODE &&
		(op_d.i_range != op_q.i_range || op_d.v_range != op_q.v_range);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			op_q  <= op_s'(OP_RST);
			dly_q <= CNT_W'(DLY_RST_CYC);
			wid_q <= CNT_W'(WID_RST_CYC);
		end else if (wr_en) begin
			if (avs_address == OFS_OPMODE) begin
				op_q <= op_d;
			end else if (avs_address == OFS_DELAY) begin
				// out-of-range values saturate rather than wrap
				dly_q <= (wr_word > 32'(DLY_MAX)) ? CNT_W'(DLY_MAX) : wr_word[CNT_W-1:0];
			end else if (avs_address == OFS_WIDTH) begin
				if (wr_word > 32'(WID_MAX)) begin
					wid_q <= CNT_W'(WID_MAX);
				end else if (wr_word < 32'(WID_MIN_CYC)) begin
					wid_q <= CNT_W'(WID_MIN_CYC);
				end else begin
					wid_q <= wr_word[CNT_W-1:0];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// load, short and panel lock
	// ----------------------------------------------------------------
	assign force_off = (mode_chg && ctrl_q.off_on_mode) || (range_chg && ctrl_q.off_on_range);
	assign load_acc  = panel_keys.load && (!lock_q || load_on);
	assign short_acc = panel_keys.short_key && ctrl_q.short_func_en && !lock_q &&
		(!ctrl_q.short_safety || load_on);
	assign lock_led  = lock_q;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			load_on <= 1'b0;
		end else if (ce) begin
			if (force_off) begin
				load_on <= 1'b0;
			end else if (load_acc) begin
				load_on <= !load_on;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			short_on <= 1'b0;
		end else if (ce) begin
			if (!ctrl_q.short_func_en) begin
				short_on <= 1'b0;
			end else if (short_acc) begin
				short_on <= !short_on;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			lock_q       <= 1'b0;
			key_other_ok <= 1'b0;
		end else if (ce) begin
			if (panel_keys.shift_clear) begin
				lock_q <= !lock_q;
			end
			key_other_ok <= panel_keys.other && !lock_q;
		end
	end

	// ----------------------------------------------------------------
	// trigger input: synchronise, edge, delay
	// ----------------------------------------------------------------
	lstc_sync u_in_sync (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.ce      (ce),
		.pin     (trig_in_pin),
		.level   (trig_in_s)
	);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			trig_in_prev_q <= 1'b0;
			trig_action    <= 1'b0;
		end else if (ce) begin
			trig_in_prev_q <= trig_in_s;
			trig_action    <= dly_done && ctrl_q.trig_in_en;
		end
	end

	// edges arriving during a running delay are dropped, not queued
	assign in_edge   = trig_in_s && !trig_in_prev_q;
	assign dly_start = in_edge && ctrl_q.trig_in_en && !dly_busy;

	lstc_timer u_dly (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.ce       (ce),
		.clear    (!ctrl_q.trig_in_en),
		.start    (dly_start),
		.load_val (dly_q),
		.busy     (dly_busy),
		.done     (dly_done)
	);

	// ----------------------------------------------------------------
	// trigger output pulse
	// ----------------------------------------------------------------
	assign out_start    = trig_out_req && ctrl_q.trig_out_en && !out_busy;
	assign trig_out_pin = out_busy;

	// busy lasts load_val + 1 cycles, hence width - 1
	lstc_timer u_out (
		.sys_clk  (sys_clk),
		.resetn   (resetn),
		.ce       (ce),
		.clear    (!ctrl_q.trig_out_en),
		.start    (out_start),
		.load_val (wid_q - 1'b1),
		.busy     (out_busy),
		.done     ()
	);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	sequence boot_on;
		ce && boot_q == ST_BOOT && nv_restore_en;
	endsequence
	sequence in_accept;
		ce && dly_start && dly_q == '0;
	endsequence
	sequence out_begin;
		ce && out_start;
	endsequence

	a_restore_pulse: assert property (boot_on |=> restore_req &&
		restore_item == $past(nv_restore_item))
		else $error("restore pulse missing");
	a_restore_quiet: assert property (restore_req |-> $past(nv_restore_en) &&
		$past(boot_q) == ST_BOOT)
		else $error("restore pulse without option");
	a_mode_off: assert property (ce && mode_chg && ctrl_q.off_on_mode |=> !load_on)
		else $error("load stayed on after mode change");
	a_mode_keep: assert property (ce && mode_chg && !ctrl_q.off_on_mode &&
		!range_chg && !load_acc && load_on |=> load_on)
		else $error("load dropped on mode change");
	a_range_keep: assert property (ce && range_chg && !ctrl_q.off_on_range &&
		!mode_chg && !load_acc && load_on |=> load_on)
		else $error("load dropped on range change");
	a_short_safe: assert property (ce && panel_keys.short_key && ctrl_q.short_safety &&
		!load_on |=> $stable(short_on) || !short_on)
		else $error("short taken with load off");
	a_short_gate: assert property (ce && !ctrl_q.short_func_en |=> !short_on)
		else $error("short active while disabled");
	a_lock_load: assert property (ce && lock_q && panel_keys.load && !load_on |=> !load_on)
		else $error("locked panel turned load on");
	a_lock_off: assert property (ce && lock_q && panel_keys.load && load_on &&
		!force_off |=> !load_on)
		else $error("locked panel could not turn load off");
	a_in_gate: assert property (ce && !ctrl_q.trig_in_en |=> !trig_action)
		else $error("action from disabled trigger input");
	a_in_zero: assert property (in_accept ##1 ce |=> trig_action)
		else $error("zero delay action late");
	a_out_gate: assert property (ce && !ctrl_q.trig_out_en |=> !trig_out_pin)
		else $error("pulse on disabled trigger output");
	a_out_start: assert property (out_begin |=> trig_out_pin ##1 (trig_out_pin || !ce))
		else $error("output pulse too short");

endmodule // lstc_core
`default_nettype wire

// File: core/lstc_pkg.sv
// shared constants, register map and carrier types for the load switch
// and trigger control block; assumes a 25 MHz system clock
package lstc_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 40;
	localparam int CNT_W         = 17;
	localparam int DLY_MAX_NS    = 5000000;
	localparam int DLY_RST_NS    = 0;
	localparam int WID_MIN_NS    = 2500;
	localparam int WID_MAX_NS    = 5000000;
	localparam int WID_RST_NS    = 10000;
	localparam int DLY_MAX_CYC   = DLY_MAX_NS / CLK_PERIOD_NS;
	localparam int DLY_RST_CYC   = DLY_RST_NS / CLK_PERIOD_NS;
	localparam int WID_MIN_CYC   = (WID_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WID_MAX_CYC   = WID_MAX_NS / CLK_PERIOD_NS;
	localparam int WID_RST_CYC   = WID_RST_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int          ADDR_W     = 5;
	localparam logic [4:0]  OFS_CTRL   = 5'h00;
	localparam logic [4:0]  OFS_OPMODE = 5'h04;
	localparam logic [4:0]  OFS_DELAY  = 5'h08;
	localparam logic [4:0]  OFS_WIDTH  = 5'h0C;
	localparam logic [4:0]  OFS_STATUS = 5'h10;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		constant_current_mode,
		constant_voltage_mode,
		constant_resistance_mode,
		constant_power_mode
	} op_mode_e;

	typedef enum logic [1:0] {
		restore_load_setting,
		restore_last_program,
		restore_normal_sequence,
		restore_fast_sequence
	} restore_item_e;

	typedef struct packed {
		logic          trig_out_en;
		logic          trig_in_en;
		logic          short_func_en;
		logic          short_safety;
		logic          off_on_range;
		logic          off_on_mode;
		restore_item_e restore_item;
		logic          restore_en;
	} ctrl_s;

	typedef struct packed {
		logic     v_range;
		logic     i_range;
		op_mode_e mode;
	} op_s;

	typedef struct packed {
		logic load;
		logic short_key;
		logic shift_clear;
		logic other;
	} keys_s;

	typedef enum logic {ST_BOOT, ST_RUN} boot_e;

	localparam logic [8:0] CTRL_RST = 9'h158;
	localparam logic [3:0] OP_RST   = 4'h0;

endpackage

// File: core/lstc_sync.sv
// two-stage synchroniser for one pin level
// assumes the pin is asynchronous to sys_clk
`timescale 1ns/10ps
`default_nettype none
module lstc_sync (
	input  wire logic sys_clk,
	input  wire logic resetn,
	input  wire logic ce,
	input  wire logic pin,
	output logic      level
);
	logic meta_q;

	// first stage feeds only the second
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= 1'b0;
			level  <= 1'b0;
		end else if (ce) begin
			meta_q <= pin;
			level  <= meta_q;
		end
	end
endmodule // lstc_sync
`default_nettype wire

// File: core/lstc_timer.sv
// down-counting interval timer on the system clock
// assumes start and clear are synchronous to sys_clk
`timescale 1ns/10ps
`default_nettype none
module lstc_timer
	import lstc_pkg::*;
#(
	parameter int W = CNT_W
) (
	input  wire logic         sys_clk,
	input  wire logic         resetn,
	input  wire logic         ce,
	input  wire logic         clear,
	input  wire logic         start,
	input  wire logic [W-1:0] load_val,
	output logic              busy,
	output logic              done
);
	logic [W-1:0] cnt_q;

	// one count per 40 ns clock, the same as the one-cycle step of the delay and width settings
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			cnt_q <= '0;
			busy  <= 1'b0;
		end else if (ce) begin
			if (clear) begin
				busy <= 1'b0;
			end else if (start) begin
				cnt_q <= load_val;
				busy  <= 1'b1;
			end else if (busy) begin
				if (cnt_q == '0) begin
					busy <= 1'b0;
				end else begin
					cnt_q <= cnt_q - 1'b1;
				end
			end
		end
	end

	assign done = busy && (cnt_q == '0) && !clear;
endmodule // lstc_timer
`default_nettype wire

// File: test/lstc_trig_equip.sv
// external equipment on the trigger terminals: fires input pulses and
// measures output pulses; assumes the same sys_clk as the block
`timescale 1ns/10ps
`default_nettype none
module lstc_trig_equip (
	input  wire logic   sys_clk,
	input  wire logic   trig_out_pin,
	output logic        trig_in_pin,
	output logic [16:0] out_width,
	output logic [7:0]  out_count
);
	logic [16:0] run = '0;
	initial trig_in_pin = 1'b0;
	initial out_width = '0;
	initial out_count = '0;

	// ----------------------------------------------------------------
	// input pulse: 3 cycles high then 3 low, wider than the sync chain
	// ----------------------------------------------------------------
	task automatic fire();
		@(posedge sys_clk);
		trig_in_pin <= 1'b1;
		repeat (3) @(posedge sys_clk);
		trig_in_pin <= 1'b0;
		repeat (3) @(posedge sys_clk);
	endtask

	// ----------------------------------------------------------------
	// output pulse width in whole clock cycles
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (trig_out_pin === 1'b1) begin
			run <= run + 17'h0_0001;
		end else if (run != '0) begin
			out_width <= run;
			out_count <= out_count + 8'h01;
			run       <= '0;
		end
	end
endmodule // lstc_trig_equip
`default_nettype wire

// File: test/load_switch_trigger_control_tb_top.sv
// self-checking bench for the load switch and trigger control block
// assumes lstc_pkg, lstc_core and lstc_trig_equip are compiled first
`timescale 1ns/10ps
`default_nettype none
module load_switch_trigger_control_tb_top
	import lstc_pkg::*;
;
	// short counts keep the run small; expectations follow from them
	localparam int         SIM_MAX = 2000;
	localparam logic [3:0] K_LOAD  = 4'h8;
	localparam logic [3:0] K_SHORT = 4'h4;
	localparam logic [3:0] K_LOCK  = 4'h2;
	localparam logic [3:0] K_OTHER = 4'h1;

	logic              sys_clk         = 1'b0;
	logic              resetn          = 1'b0;
	logic              ce              = 1'b1;
	logic [ADDR_W-1:0] avs_address     = '0;
	logic              avs_read        = 1'b0;
	logic              avs_write       = 1'b0;
	logic [31:0]       avs_writedata   = '0;
	logic [31:0]       avs_readdata;
	logic              avs_waitrequest;
	logic              nv_restore_en   = 1'b1;
	logic [1:0]        nv_restore_item = 2'h2;
	keys_s             panel_keys      = '0;
	logic              trig_out_req    = 1'b0;
	logic              key_other_ok, load_on, short_on, lock_led;
	logic              restore_req, trig_in_pin, trig_out_pin, trig_action;
	logic [1:0]        restore_item, rst_item;
	op_s               op_out;
	logic [16:0]       out_width;
	logic [7:0]        out_count;
	logic [31:0]       rd;
	logic              ok_seen;
	int                err_count   = 0;
	int                comparisons = 0;
	int                cyc = 0, act_cyc = 0, act_cnt = 0, rst_cnt = 0;
	int                n, lat0, lat1;

	lstc_core #(.DLY_MAX(SIM_MAX), .WID_MAX(SIM_MAX)) uut (
		.sys_clk(sys_clk), .resetn(resetn), .ce(ce),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'hF),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.nv_restore_en(nv_restore_en), .nv_restore_item(nv_restore_item),
		.panel_keys(panel_keys), .key_other_ok(key_other_ok), .load_on(load_on),
		.short_on(short_on), .lock_led(lock_led), .op_out(op_out),
		.restore_req(restore_req), .restore_item(restore_item),
		.trig_in_pin(trig_in_pin), .trig_out_req(trig_out_req),
		.trig_out_pin(trig_out_pin), .trig_action(trig_action));

	lstc_trig_equip equip (
		.sys_clk(sys_clk), .trig_out_pin(trig_out_pin), .trig_in_pin(trig_in_pin),
		.out_width(out_width), .out_count(out_count));

	always #20 sys_clk = ~sys_clk;

	// ----------------------------------------------------------------
	// event recorders
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (trig_action === 1'b1) begin
			act_cyc <= cyc;
			act_cnt <= act_cnt + 1;
		end
		if (restore_req === 1'b1) begin
			rst_cnt  <= rst_cnt + 1;
			rst_item <= restore_item;
		end
	end

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic report_and_stop();
		$display("comparisons %0d, mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask

	task automatic stall(input string msg);
		err_count++;
		$display("mismatch at %0t: no answer from %s", $time, msg);
		report_and_stop();
	endtask

	// one Avalon access; ends one edge after the answer so outputs have settled
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		avs_address   <= a;
		avs_writedata <= d;
		avs_write     <= wr;
		avs_read      <= !wr;
		for (i = 0; i < 20; i++) begin
			@(posedge sys_clk);
			if (avs_waitrequest === 1'b0) break;
		end
		if (avs_waitrequest !== 1'b0) stall("bus");
		rd = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic key(input logic [3:0] k);
		@(posedge sys_clk);
		panel_keys <= keys_s'(k);
		@(posedge sys_clk);
		panel_keys <= '0;
		@(posedge sys_clk);
		ok_seen = key_other_ok;
	endtask

	task automatic do_reset();
		resetn <= 1'b0;
		repeat (5) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (4) @(posedge sys_clk);
	endtask

	task automatic trig_in(output int lat);
		int i, t0;
		t0 = cyc;
		n  = act_cnt;
		equip.fire();
		for (i = 0; i < 3000 && act_cnt == n; i++) @(posedge sys_clk);
		if (act_cnt == n) stall("trigger input");
		lat = act_cyc - t0;
	endtask

	task automatic trig_out();
		int i;
		n = out_count;
		@(posedge sys_clk);
		trig_out_req <= 1'b1;
		@(posedge sys_clk);
		trig_out_req <= 1'b0;
		for (i = 0; i < 600 && out_count == n; i++) @(posedge sys_clk);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (50000) @(posedge sys_clk);
		err_count++;
		report_and_stop();
	end

	initial begin
		do_reset();
		check(32'(rst_cnt), 32'h0000_0001, "restore pulses");
		check(32'(rst_item), 32'h0000_0002, "restore item");
		bus(1'b0, OFS_CTRL, '0);
		check(rd, 32'h0000_015D, "ctrl restored");
		nv_restore_en <= 1'b0;
		n = rst_cnt;
		do_reset();
		check(32'(rst_cnt - n), 32'h0000_0000, "restore while off");
		// the stored item is still copied at boot, only the pulse is suppressed
		bus(1'b0, OFS_CTRL, '0);
		check(rd, 32'h0000_015C, "ctrl reset");
		bus(1'b0, OFS_OPMODE, '0);
		check(rd, 32'h0000_0000, "opmode reset");
		bus(1'b0, OFS_DELAY, '0);
		check(rd, 32'h0000_0000, "delay reset");
		bus(1'b0, OFS_WIDTH, '0);
		check(rd, 32'h0000_00FA, "width reset");
		bus(1'b0, 5'h14, '0);
		check(rd, 32'h0000_0000, "unmapped read");
		// load switch-off on mode and range change
		key(K_LOAD);
		check(32'(load_on), 32'h0000_0001, "load on");
		bus(1'b1, OFS_OPMODE, 32'h0000_0001);
		check(32'(load_on), '0, "mode off");
		check(32'(op_out), 32'h0000_0001, "op out");
		key(K_LOAD);
		bus(1'b1, OFS_CTRL, 32'h0000_0150);
		bus(1'b1, OFS_OPMODE, 32'h0000_0002);
		check(32'(load_on), 32'h0000_0001, "mode kept");
		bus(1'b1, OFS_OPMODE, 32'h0000_0006);
		check(32'(load_on), '0, "range off");
		key(K_LOAD);
		bus(1'b1, OFS_CTRL, 32'h0000_0140);
		bus(1'b1, OFS_OPMODE, 32'h0000_000E);
		check(32'(load_on), 32'h0000_0001, "range kept");
		// short key gating
		bus(1'b1, OFS_CTRL, 32'h0000_0160);
		key(K_LOAD);
		key(K_SHORT);
		check(32'(short_on), '0, "short while off");
		key(K_LOAD);
		key(K_SHORT);
		check(32'(short_on), 32'h0000_0001, "short while on");
		key(K_SHORT);
		check(32'(short_on), '0, "short toggled");
		key(K_LOAD);
		bus(1'b1, OFS_CTRL, 32'h0000_0140);
		key(K_SHORT);
		check(32'(short_on), 32'h0000_0001, "short any time");
		bus(1'b1, OFS_CTRL, 32'h0000_0100);
		@(posedge sys_clk);
		check(32'(short_on), '0, "short cleared");
		key(K_SHORT);
		check(32'(short_on), '0, "short disabled");
		// panel lock
		key(K_OTHER);
		check(32'(ok_seen), 32'h0000_0001, "key unlocked");
		key(K_LOCK);
		check(32'(lock_led), 32'h0000_0001, "lock shown");
		bus(1'b0, OFS_STATUS, '0);
		check(rd, 32'h0000_0024, "status locked");
		key(K_OTHER);
		check(32'(ok_seen), '0, "key locked");
		key(K_LOAD);
		check(32'(load_on), '0, "load key locked");
		key(K_LOCK);
		key(K_LOAD);
		key(K_LOCK);
		key(K_LOAD);
		check(32'(load_on), '0, "load off while locked");
		key(K_LOCK);
		check(32'(lock_led), '0, "unlocked");
		// trigger input
		n = act_cnt;
		equip.fire();
		repeat (60) @(posedge sys_clk);
		check(32'(act_cnt - n), '0, "input disabled");
		bus(1'b1, OFS_CTRL, 32'h0000_01C0);
		trig_in(lat0);
		bus(1'b1, OFS_DELAY, 32'h0000_0028);
		trig_in(lat1);
		check(32'(lat1 - lat0), 32'h0000_0028, "input delay");
		bus(1'b1, OFS_DELAY, 32'h0000_1388);
		bus(1'b0, OFS_DELAY, '0);
		check(rd, 32'h0000_07D0, "delay ceiling");
		// trigger output
		trig_out();
		check(32'(out_count), 32'(n + 1), "out pulse");
		check(32'(out_width), 32'h0000_00FA, "default width");
		bus(1'b1, OFS_WIDTH, 32'h0000_000A);
		bus(1'b0, OFS_WIDTH, '0);
		check(rd, 32'h0000_003F, "width floor");
		trig_out();
		check(32'(out_width), 32'h0000_003F, "min width");
		// ten frozen cycles inside the pulse stretch it by ten
		fork
			trig_out();
			begin
				repeat (20) @(posedge sys_clk);
				ce <= 1'b0;
				repeat (10) @(posedge sys_clk);
				ce <= 1'b1;
			end
		join
		check(32'(out_width), 32'h0000_0049, "width frozen by ce");
		bus(1'b1, OFS_CTRL, 32'h0000_00C0);
		trig_out();
		check(32'(out_count), 32'(n), "output disabled");
		report_and_stop();
	end
endmodule // load_switch_trigger_control_tb_top
`default_nettype wire
